// file: verilog/rxo_top.sv
// Receive output stage: presentation, parity, clocking and framing
//
// How it works
// - With decoding on, status outputs carry the character's decoder status.
// - Parity select not low: parity output is odd parity of byte output.
// - Parity select low: parity output driver is released to high-Z.
// - Rate low, recovered clocking: complementary clock pair at char rate.
// - Rate high, recovered clocking: complementary pair at half char rate.
// - Training clocking ignores rate select; A and C follow training clock.
// - Training rate high: A and C clocks are half-rate like training clock.
// - Training rate low: A and C clocks are full-rate training clock.
// - Pattern select mid: framer seeks both forms of the 8-bit comma.
// - Pattern select high: framer seeks both forms of full K28.5.
// - Half-rate training clock: outputs update on both clock edges.
// - Ternary selects decode low, mid, high; floating reads as mid.
// - Decoder mode low bypasses decoder, forces recovered clocking.
// - Source select mid: each pair follows its own recovered clock.
// - Reframe allow high lets all four framers frame.
`timescale 1ns/1ns
module rxo_top (
  input  wire logic                     clock_i,        // System clock
  input  wire logic                     resetn_i,       // Async, low
  input  wire logic                     local_training_clock_i, // Trg clk
  input  wire logic [3:0]               char_valid_i,   // New char strobe
  input  rxo_pkg::rxo_char_s [3:0]      char_in_i,      // Decoded chars
  input  wire logic                     parity_control_select_hi_i, // Pin
  input  wire logic                     parity_control_select_lo_i, // Pin
  input  wire logic                     rx_clock_source_select_hi_i, // Pin
  input  wire logic                     rx_clock_source_select_lo_i, // Pin
  input  wire logic                     framing_pattern_select_hi_i, // Pin
  input  wire logic                     framing_pattern_select_lo_i, // Pin
  input  wire logic                     decoder_mode_select_hi_i, // Pin
  input  wire logic                     decoder_mode_select_lo_i, // Pin
  input  wire logic                     rx_clock_rate_select_i, // Pin
  input  wire logic                     training_clock_rate_select_i, // Pin
  input  wire logic                     reframe_allow_i, // Pin
  output logic [3:0][7:0]               rx_byte_out_o,  // Byte outputs
  output logic [3:0][2:0]               rx_char_status_o, // Status outputs
  output logic [3:0]                    rx_odd_parity_out_o, // Parity
  output logic [3:0]                    rx_odd_parity_oe_o, // Parity drive
  output logic [3:0]                    rx_char_clock_pair_true_o, // Clk +
  output logic [3:0]                    rx_char_clock_pair_comp_o, // Clk -
  output logic [3:0]                    rx_char_clock_pair_oe_o, // Clk drive
  output logic                          frame_enable_o, // Framers allowed
  output logic [3:0]                    frame_hit_o     // Pattern found
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic odd_par(input logic [7:0] d);
    odd_par = ~(^d);
  endfunction : odd_par

  function automatic logic frame_match(input logic [9:0]       raw,
                                       input rxo_pkg::rxo_tri_e sel);
    logic [9:0] m;
    m = rxo_pkg::FULL_MASK;
    frame_match = 1'b0;
    unique case (sel)
      rxo_pkg::TRI_MID: begin
        m = rxo_pkg::COMMA_MASK;
        frame_match = ((raw & m) == (rxo_pkg::K28_5_NEG & m)) ||
                      ((raw & m) == (rxo_pkg::K28_5_POS & m));
      end
      rxo_pkg::TRI_HIGH: begin
        frame_match = (raw == rxo_pkg::K28_5_NEG) ||
                      (raw == rxo_pkg::K28_5_POS);
      end
      // Reserved test level never matches; the host keeps it off
      rxo_pkg::TRI_LOW: begin
        frame_match = 1'b0;
      end
      default: begin
        frame_match = 1'b0;
      end
    endcase
  endfunction : frame_match

  function automatic rxo_pkg::rxo_out_s present(
      input rxo_pkg::rxo_char_s c,
      input logic               bypass);
    rxo_pkg::rxo_out_s o;
    if (bypass) begin
      o.data   = c.raw[9:2];
      o.status = {c.comma, c.raw[1:0]};
    end else begin
      o.data   = c.data;
      o.status = c.status;
    end
    o.par   = odd_par(o.data);
    present = o;
  endfunction : present

  // ----------------------------------------------------------------
  // Static selects
  // ----------------------------------------------------------------
  rxo_pkg::rxo_tri_e par_sel;
  rxo_pkg::rxo_tri_e src_sel;
  rxo_pkg::rxo_tri_e frm_sel;
  rxo_pkg::rxo_tri_e dec_sel;

  rxo_tri_sync u_par_sel (
    .clock_i    (clock_i),
    .resetn_i   (resetn_i),
    .above_hi_i (parity_control_select_hi_i),
    .below_lo_i (parity_control_select_lo_i),
    .level_o    (par_sel)
  );

  rxo_tri_sync u_src_sel (
    .clock_i    (clock_i),
    .resetn_i   (resetn_i),
    .above_hi_i (rx_clock_source_select_hi_i),
    .below_lo_i (rx_clock_source_select_lo_i),
    .level_o    (src_sel)
  );

  rxo_tri_sync u_frm_sel (
    .clock_i    (clock_i),
    .resetn_i   (resetn_i),
    .above_hi_i (framing_pattern_select_hi_i),
    .below_lo_i (framing_pattern_select_lo_i),
    .level_o    (frm_sel)
  );

  rxo_tri_sync u_dec_sel (
    .clock_i    (clock_i),
    .resetn_i   (resetn_i),
    .above_hi_i (decoder_mode_select_hi_i),
    .below_lo_i (decoder_mode_select_lo_i),
    .level_o    (dec_sel)
  );

  // ----------------------------------------------------------------
  // System-domain state
  // ----------------------------------------------------------------
  logic [2:0]                 bin1_r;
  logic [2:0]                 bin2_r;
  logic [2:0]                 bin1_nxt;
  logic [2:0]                 bin2_nxt;
  logic                       bypass;
  logic                       trg_mode;
  logic                       trg_mode_r;
  logic                       trg_mode_nxt;
  rxo_pkg::rxo_out_s [3:0]    out_r;
  rxo_pkg::rxo_out_s [3:0]    out_nxt;
  logic [3:0]                 upd_r;
  logic [3:0]                 upd_nxt;
  logic [3:0]                 clk_t_r;
  logic [3:0]                 clk_t_nxt;
  logic [3:0]                 fhit_r;
  logic [3:0]                 fhit_nxt;
  logic                       par_oe_r;
  logic                       par_oe_nxt;
  rxo_pkg::rxo_out_s [3:0]    snap_r;
  rxo_pkg::rxo_out_s [3:0]    snap_nxt;
  logic                       req_r;
  logic                       req_nxt;
  logic                       dirty_r;
  logic                       dirty_nxt;
  logic                       ack1_r;
  logic                       ack2_r;
  logic                       ack1_nxt;
  logic                       ack2_nxt;
  logic                       load;

  // Training-domain state, declared here for the crossing
  logic                       rq1_r;
  logic                       rq2_r;
  logic                       seen_p_r;
  logic                       seen_n_r;

  // ----------------------------------------------------------------
  // System domain: presentation, recovered clocks, framer, snapshot
  // ----------------------------------------------------------------
  always_comb begin
    bin1_nxt = {reframe_allow_i, training_clock_rate_select_i,
                rx_clock_rate_select_i};
    bin2_nxt = bin1_r;
    ack1_nxt = seen_p_r ^ seen_n_r;
    ack2_nxt = ack1_r;
    bypass   = (dec_sel == rxo_pkg::TRI_LOW);
    // Bypassed decoding only works with per-channel clocks
    trg_mode     = (src_sel == rxo_pkg::TRI_LOW) && !bypass;
    trg_mode_nxt = trg_mode;
    par_oe_nxt   = (par_sel != rxo_pkg::TRI_LOW);
    out_nxt  = out_r;
    upd_nxt  = char_valid_i;
    clk_t_nxt = clk_t_r;
    fhit_nxt  = 4'h0;
    for (int i = 0; i < rxo_pkg::NCH; i++) begin
      if (char_valid_i[i]) begin
        out_nxt[i] = present(char_in_i[i], bypass);
      end
      if (bin2_r[0]) begin
        // Half rate: one clock edge per character
        clk_t_nxt[i] = clk_t_r[i] ^ upd_r[i];
      end else begin
        // Full rate: low with new data, rises a cycle later
        clk_t_nxt[i] = !char_valid_i[i];
      end
      fhit_nxt[i] = char_valid_i[i] && bin2_r[2] &&
                    frame_match(char_in_i[i].raw, frm_sel);
    end
    // Hand the latest words to the training domain when it is idle
    load      = dirty_r && (req_r == ack2_r);
    snap_nxt  = load ? out_r : snap_r;
    req_nxt   = load ? !req_r : req_r;
    // A character in the cycle of a snapshot keeps the flag set
    dirty_nxt = (dirty_r && !load) || (|char_valid_i);
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bin1_r     <= 3'h0;
      bin2_r     <= 3'h0;
      ack1_r     <= rxo_pkg::TOG_RST;
      ack2_r     <= rxo_pkg::TOG_RST;
      trg_mode_r <= 1'b0;
      par_oe_r   <= 1'b0;
      out_r      <= {4{rxo_pkg::OUT_RST}};
      upd_r      <= 4'h0;
      clk_t_r    <= {4{rxo_pkg::CLK_RST}};
      fhit_r     <= 4'h0;
      snap_r     <= '0;
      req_r      <= rxo_pkg::TOG_RST;
      dirty_r    <= 1'b0;
    end else begin
      bin1_r     <= bin1_nxt;
      bin2_r     <= bin2_nxt;
      ack1_r     <= ack1_nxt;
      ack2_r     <= ack2_nxt;
      trg_mode_r <= trg_mode_nxt;
      par_oe_r   <= par_oe_nxt;
      out_r      <= out_nxt;
      upd_r      <= upd_nxt;
      clk_t_r    <= clk_t_nxt;
      fhit_r     <= fhit_nxt;
      snap_r     <= snap_nxt;
      req_r      <= req_nxt;
      dirty_r    <= dirty_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Training domain, rising edge
  // ----------------------------------------------------------------
  // The output word is p ^ n so that either edge may load it without
  // two processes driving one register.
  logic                       tr1_r;
  logic                       tr2_r;
  logic                       rq1_nxt;
  logic                       rq2_nxt;
  logic                       tr1_nxt;
  logic                       tr2_nxt;
  logic                       seen_p_nxt;
  logic                       seen_n_nxt;
  rxo_pkg::rxo_out_s [3:0]    p_r;
  rxo_pkg::rxo_out_s [3:0]    p_nxt;
  rxo_pkg::rxo_out_s [3:0]    n_r;
  rxo_pkg::rxo_out_s [3:0]    n_nxt;

  always_comb begin
    rq1_nxt    = req_r;
    rq2_nxt    = rq1_r;
    tr1_nxt    = training_clock_rate_select_i;
    tr2_nxt    = tr1_r;
    seen_p_nxt = seen_p_r;
    p_nxt      = p_r;
    if (rq2_r ^ seen_p_r ^ seen_n_r) begin
      seen_p_nxt = !seen_p_r;
      p_nxt      = snap_r ^ n_r;
    end
  end

  always_ff @(posedge local_training_clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rq1_r    <= rxo_pkg::TOG_RST;
      rq2_r    <= rxo_pkg::TOG_RST;
      tr1_r    <= 1'b0;
      tr2_r    <= 1'b0;
      seen_p_r <= rxo_pkg::TOG_RST;
      p_r      <= {4{rxo_pkg::OUT_RST}};
    end else begin
      rq1_r    <= rq1_nxt;
      rq2_r    <= rq2_nxt;
      tr1_r    <= tr1_nxt;
      tr2_r    <= tr2_nxt;
      seen_p_r <= seen_p_nxt;
      p_r      <= p_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Training domain, falling edge (half-rate training clock only)
  // ----------------------------------------------------------------
  always_comb begin
    seen_n_nxt = seen_n_r;
    n_nxt      = n_r;
    if (tr2_r && (rq2_r ^ seen_p_r ^ seen_n_r)) begin
      seen_n_nxt = !seen_n_r;
      n_nxt      = snap_r ^ p_r;
    end
  end

  always_ff @(negedge local_training_clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      seen_n_r <= rxo_pkg::TOG_RST;
      n_r      <= '0;
    end else begin
      seen_n_r <= seen_n_nxt;
      n_r      <= n_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------
  // The training clock is passed through, not re-timed, so the pair
  // keeps its frequency and duty cycle; rate selects are not consulted.
  rxo_pkg::rxo_out_s [3:0]    trg_word;

  always_comb begin
    trg_word = p_r ^ n_r;
    for (int i = 0; i < rxo_pkg::NCH; i++) begin
      if (trg_mode_r) begin
        rx_byte_out_o[i]       = trg_word[i].data;
        rx_char_status_o[i]    = trg_word[i].status;
        rx_odd_parity_out_o[i] = trg_word[i].par;
        rx_char_clock_pair_true_o[i] =
          rxo_pkg::TRG_CLK_CH[i] & local_training_clock_i;
        rx_char_clock_pair_comp_o[i] =
          rxo_pkg::TRG_CLK_CH[i] & !local_training_clock_i;
        rx_char_clock_pair_oe_o[i] = rxo_pkg::TRG_CLK_CH[i];
      end else begin
        rx_byte_out_o[i]       = out_r[i].data;
        rx_char_status_o[i]    = out_r[i].status;
        rx_odd_parity_out_o[i] = out_r[i].par;
        rx_char_clock_pair_true_o[i] = clk_t_r[i];
        rx_char_clock_pair_comp_o[i] = !clk_t_r[i];
        rx_char_clock_pair_oe_o[i]   = 1'b1;
      end
      rx_odd_parity_oe_o[i] = par_oe_r;
    end
    frame_enable_o = bin2_r[2];
    frame_hit_o    = fhit_r;
  end

endmodule : rxo_top

// file: verilog/rxo_pkg.sv
// Shared constants and types for the receive output stage
package rxo_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int unsigned NCH       = 4;
  localparam int unsigned RAW_W     = 10;
  localparam int unsigned DATA_W    = 8;
  localparam int unsigned STAT_W    = 3;

  // ----------------------------------------------------------------
  // Channel indices that drive clocks while training clocking is used
  // ----------------------------------------------------------------
  localparam logic [3:0]  TRG_CLK_CH = 4'h5;      // Channels A and C

  // ----------------------------------------------------------------
  // Framing patterns, both running-disparity forms of the full
  // special character and the mask that keeps its leading 8 bits
  // ----------------------------------------------------------------
  localparam logic [9:0]  K28_5_NEG   = 10'h0FA;
  localparam logic [9:0]  K28_5_POS   = 10'h305;
  localparam logic [9:0]  COMMA_MASK  = 10'h3FC;
  localparam logic [9:0]  FULL_MASK   = 10'h3FF;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic        CLK_RST     = 1'h0;
  localparam logic        TOG_RST     = 1'h0;

  // ----------------------------------------------------------------
  // Ternary select levels
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TRI_LOW  = 2'b00,
    TRI_MID  = 2'b01,
    TRI_HIGH = 2'b10
  } rxo_tri_e;

  // ----------------------------------------------------------------
  // Character from the decoder and the presented output word
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [9:0] raw;      // Undecoded 10-bit character
    logic [7:0] data;     // Decoded byte
    logic [2:0] status;   // Decoder status
    logic       comma;    // Comma seen in this character
  } rxo_char_s;

  typedef struct packed {
    logic [7:0] data;
    logic [2:0] status;
    logic       par;
  } rxo_out_s;
  localparam rxo_out_s OUT_RST = '{data: 8'h00, status: 3'h0, par: 1'h1};

endpackage : rxo_pkg

// file: verilog/rxo_tri_sync.sv
// Ternary select pin: synchroniser and level decode
`timescale 1ns/1ns
module rxo_tri_sync (
  input  wire logic        clock_i,    // System clock
  input  wire logic        resetn_i,   // Async reset, active low
  input  wire logic        above_hi_i, // Pin above the high threshold
  input  wire logic        below_lo_i, // Pin below the low threshold
  output rxo_pkg::rxo_tri_e level_o    // Decoded level
);

  logic [1:0]       s1_r;
  logic [1:0]       s2_r;
  logic [1:0]       s1_nxt;
  logic [1:0]       s2_nxt;
  rxo_pkg::rxo_tri_e lvl_r;
  rxo_pkg::rxo_tri_e lvl_nxt;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  always_comb begin
    s1_nxt = {above_hi_i, below_lo_i};
    s2_nxt = s1_r;
    // Neither comparator tripped means a floating pin
    if (s2_r[1] && !s2_r[0]) begin
      lvl_nxt = rxo_pkg::TRI_HIGH;
    end else if (s2_r[0] && !s2_r[1]) begin
      lvl_nxt = rxo_pkg::TRI_LOW;
    end else begin
      lvl_nxt = rxo_pkg::TRI_MID;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1_r  <= 2'h0;
      s2_r  <= 2'h0;
      lvl_r <= rxo_pkg::TRI_MID;
    end else begin
      s1_r  <= s1_nxt;
      s2_r  <= s2_nxt;
      lvl_r <= lvl_nxt;
    end
  end

  assign level_o = lvl_r;

endmodule : rxo_tri_sync

// file: tb/rxo_top_monitor.sv
// Concurrent checks on the receive output stage ports
`timescale 1ns/1ns
module rxo_top_monitor (
  input wire logic             clock_i, // Clock
  input wire logic             resetn_i, // Reset
  input wire logic             local_training_clock_i, // Trg clk
  input wire logic [3:0]       char_valid_i, // Strobe
  input rxo_pkg::rxo_char_s [3:0] char_in_i, // Chars
  input wire logic             parity_control_select_hi_i, // Pin
  input wire logic             parity_control_select_lo_i, // Pin
  input wire logic             rx_clock_source_select_hi_i, // Pin
  input wire logic             rx_clock_source_select_lo_i, // Pin
  input wire logic             framing_pattern_select_hi_i, // Pin
  input wire logic             framing_pattern_select_lo_i, // Pin
  input wire logic             decoder_mode_select_hi_i, // Pin
  input wire logic             decoder_mode_select_lo_i, // Pin
  input wire logic             rx_clock_rate_select_i, // Pin
  input wire logic             training_clock_rate_select_i, // Pin
  input wire logic             reframe_allow_i, // Pin
  input wire logic [3:0][7:0]  rx_byte_out_o, // Bytes
  input wire logic [3:0][2:0]  rx_char_status_o, // Status
  input wire logic [3:0]       rx_odd_parity_out_o, // Parity
  input wire logic [3:0]       rx_odd_parity_oe_o, // Drive
  input wire logic [3:0]       rx_char_clock_pair_true_o, // Clk +
  input wire logic [3:0]       rx_char_clock_pair_comp_o, // Clk -
  input wire logic [3:0]       rx_char_clock_pair_oe_o, // Drive
  input wire logic             frame_enable_o, // Frame en
  input wire logic [3:0]       frame_hit_o // Hit
);
  // ------------
  // Decoded selects and a settle counter
  // ------------
  wire p_low  = parity_control_select_lo_i & ~parity_control_select_hi_i;
  wire s_low  = rx_clock_source_select_lo_i & ~rx_clock_source_select_hi_i;
  wire d_low  = decoder_mode_select_lo_i & ~decoder_mode_select_hi_i;
  wire f_high = framing_pattern_select_hi_i & ~framing_pattern_select_lo_i;
  wire f_mid  = framing_pattern_select_hi_i == framing_pattern_select_lo_i;
  wire rec    = ~s_low | d_low;
  wire [10:0] cfg = {parity_control_select_hi_i, parity_control_select_lo_i,
    rx_clock_source_select_hi_i, rx_clock_source_select_lo_i,
    framing_pattern_select_hi_i, framing_pattern_select_lo_i,
    decoder_mode_select_hi_i, decoder_mode_select_lo_i,
    rx_clock_rate_select_i, training_clock_rate_select_i, reframe_allow_i};
  logic [10:0] cfg_r;
  logic [2:0]  calm_r;
  // Judge only once synchronised selects settle
  wire ok = (calm_r == 3'h7) && (cfg == cfg_r);
  wire [9:0] raw0 = char_in_i[0].raw;
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cfg_r  <= '0;
      calm_r <= 3'h0;
    end else begin
      cfg_r  <= cfg;
      calm_r <= (cfg != cfg_r) ? 3'h0 : calm_r + {2'h0, calm_r != 3'h7};
    end
  end
  function automatic logic odd_all(logic [3:0][7:0] b, logic [3:0] p,
                                   logic [3:0] oe);
    odd_all = 1'b1;
    for (int i = 0; i < 4; i++)
      if (oe[i] && !(^{b[i], p[i]})) odd_all = 1'b0;
  endfunction : odd_all
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  sequence s_lone0;
    !char_valid_i[0] ##1 ok && rec && !rx_clock_rate_select_i &&
    char_valid_i[0] ##1 !char_valid_i[0];
  endsequence
  sequence s_half0;
    ok && rec && rx_clock_rate_select_i && char_valid_i[0] ##1 1'b1;
  endsequence
  AST_PAR_ODD: assert property (odd_all(rx_byte_out_o,
    rx_odd_parity_out_o, rx_odd_parity_oe_o)) else $error("even parity");
  AST_PAR_OE: assert property (ok |-> rx_odd_parity_oe_o ==
    (p_low ? 4'h0 : 4'hF)) else $error("parity drive wrong");
  AST_REC_PAIR: assert property (ok && rec |->
    rx_char_clock_pair_comp_o == ~rx_char_clock_pair_true_o &&
    rx_char_clock_pair_oe_o == 4'hF) else $error("recovered pair");
  AST_FULL: assert property (s_lone0 |=>
    rx_char_clock_pair_true_o[0]) else $error("no full rise");
  AST_HALF: assert property (s_half0 |=> rx_char_clock_pair_true_o[0] !=
    $past(rx_char_clock_pair_true_o[0])) else $error("no half toggle");
  AST_TRG: assert property (ok && s_low && !d_low |->
    rx_char_clock_pair_oe_o == rxo_pkg::TRG_CLK_CH &&
    rx_char_clock_pair_true_o[0] == local_training_clock_i &&
    rx_char_clock_pair_true_o[2] == local_training_clock_i &&
    rx_char_clock_pair_comp_o[0] != local_training_clock_i)
    else $error("training pair");
  AST_DEC: assert property (ok && rec && !d_low && char_valid_i[0] |=>
    rx_byte_out_o[0] == $past(char_in_i[0].data) &&
    rx_char_status_o[0] == $past(char_in_i[0].status))
    else $error("decoded word wrong");
  AST_BYP: assert property (ok && d_low && char_valid_i[0] |=>
    rx_byte_out_o[0] == $past(raw0[9:2])) else $error("bypass word wrong");
  AST_FRAME_EN: assert property (ok |->
    frame_enable_o == reframe_allow_i) else $error("frame enable wrong");
  AST_HIT_FULL: assert property (ok && reframe_allow_i && f_high &&
    char_valid_i[0] && raw0 == rxo_pkg::K28_5_POS |=> frame_hit_o[0])
    else $error("full pattern missed");
  AST_HIT_COMMA: assert property (ok && reframe_allow_i && f_mid &&
    char_valid_i[0] && (raw0 & rxo_pkg::COMMA_MASK) ==
    (rxo_pkg::K28_5_NEG & rxo_pkg::COMMA_MASK) |=> frame_hit_o[0])
    else $error("comma missed");
endmodule : rxo_top_monitor
bind rxo_top rxo_top_monitor i_rxo_top_monitor (.*);

// file: tb/rxo_host_model.sv
// Host-side model latching one channel's byte output
`timescale 1ns/1ns
module rxo_host_model (
  input wire logic       true_i,  // Clock +
  input wire logic       comp_i,  // Clock -
  input wire logic       half_i,  // Half-rate capture
  input wire logic [7:0] byte_i,  // Byte
  output logic [7:0]     word_o,  // Last capture
  output int             n_cap_o  // Capture count
);
  initial begin
    word_o  = 8'h00;
    n_cap_o = 0;
  end
  // Half rate also takes complement rises
  always @(posedge true_i or posedge comp_i) begin
    if (true_i || half_i) begin
      word_o  = byte_i;
      n_cap_o = n_cap_o + 1;
    end
  end
endmodule : rxo_host_model

// file: tb/test_rx_output_clocking_parity_framing.sv
// Self-checking bench for the receive output stage
`timescale 1ns/1ns
module test_rx_output_clocking_parity_framing;
  `define CHECK(what, exp, got) begin n_compared++; \
    if ((got) !== (exp)) begin n_fail++; \
      $display("wrong value %s expected %0h seen %0h", what, exp, got); \
    end end
  localparam logic [1:0] LO = 2'h1, MI = 2'h0, HI = 2'h2;
  int n_fail = 0, n_compared = 0, host_n, n0;
  logic clock_i = 0, resetn_i, local_training_clock_i = 0, hit;
  logic [3:0] char_valid_i = 4'h0;
  rxo_pkg::rxo_char_s [3:0] char_in_i = '0;
  logic [1:0] psel = MI, ssel = MI, fsel = HI, dsel = MI;
  logic rx_clock_rate_select_i = 0, training_clock_rate_select_i = 0;
  logic reframe_allow_i = 0;
  logic [7:0] host_byte;
  logic [3:0][7:0] rx_byte_out_o;
  logic [3:0][2:0] rx_char_status_o;
  logic [3:0] rx_odd_parity_out_o, rx_odd_parity_oe_o, frame_hit_o;
  logic [3:0] rx_char_clock_pair_true_o, rx_char_clock_pair_comp_o;
  logic [3:0] rx_char_clock_pair_oe_o;
  logic frame_enable_o;
  wire parity_control_select_hi_i  = psel[1];
  wire parity_control_select_lo_i  = psel[0];
  wire rx_clock_source_select_hi_i = ssel[1];
  wire rx_clock_source_select_lo_i = ssel[0];
  wire framing_pattern_select_hi_i = fsel[1];
  wire framing_pattern_select_lo_i = fsel[0];
  wire decoder_mode_select_hi_i    = dsel[1];
  wire decoder_mode_select_lo_i    = dsel[0];
  rxo_top i_rxo_top (.*);
  rxo_host_model i_rxo_host_model (.true_i(rx_char_clock_pair_true_o[0]),
    .comp_i(rx_char_clock_pair_comp_o[0]), .half_i(rx_clock_rate_select_i),
    .byte_i(rx_byte_out_o[0]), .word_o(host_byte), .n_cap_o(host_n));
  always #2 clock_i = ~clock_i;
  always begin
    #61 local_training_clock_i = ~local_training_clock_i;
    #64 local_training_clock_i = ~local_training_clock_i;
  end
  // ------------
  // Drivers
  // ------------
  task automatic tick(int n = 1);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : tick
  task automatic cfg(logic [1:0] p, s, f, d);
    psel = p;
    ssel = s;
    fsel = f;
    dsel = d;
    tick(10);
  endtask : cfg
  // One-edge strobe, then gather the framer pulse
  task automatic send(int ch, logic [9:0] raw, logic [7:0] d,
                      logic [2:0] st);
    char_in_i[ch] = {raw, d, st, 1'h1};
    char_valid_i[ch] = 1'b1;
    tick();
    char_valid_i[ch] = 1'b0;
    hit = frame_hit_o[ch];
    tick();
    hit = hit | frame_hit_o[ch];
    tick(4);
  endtask : send
  // ------------
  // Scenarios
  // ------------
  task automatic t_decode;
    cfg(HI, MI, HI, MI);
    send(0, 10'h155, 8'hA5, 3'h2);
    `CHECK("byte", 8'hA5, rx_byte_out_o[0])
    `CHECK("status", 3'h2, rx_char_status_o[0])
    `CHECK("parity", 1'h1, rx_odd_parity_out_o[0])
    `CHECK("host byte", 8'hA5, host_byte)
    send(3, 10'h155, 8'h07, 3'h0);
    `CHECK("parity d", 1'h0, rx_odd_parity_out_o[3])
    `CHECK("parity drive", 4'hF, rx_odd_parity_oe_o)
  endtask : t_decode
  task automatic t_parity;
    cfg(LO, MI, HI, MI);
    `CHECK("parity off", 4'h0, rx_odd_parity_oe_o)
    cfg(MI, MI, HI, MI);
    `CHECK("parity float", 4'hF, rx_odd_parity_oe_o)
    cfg(HI, MI, HI, MI);
  endtask : t_parity
  task automatic t_half;
    rx_clock_rate_select_i = 1'b1;
    tick(10);
    n0 = host_n;
    send(0, 10'h155, 8'h3C, 3'h0);
    send(0, 10'h155, 8'hC3, 3'h0);
    `CHECK("captures", n0 + 2, host_n)
    `CHECK("host half", 8'hC3, host_byte)
    rx_clock_rate_select_i = 1'b0;
    tick(10);
  endtask : t_half
  task automatic t_bypass;
    cfg(HI, LO, HI, LO);
    send(0, 10'h2B6, 8'h00, 3'h0);
    `CHECK("raw high", 8'hAD, rx_byte_out_o[0])
    `CHECK("raw low", 3'h6, rx_char_status_o[0])
    `CHECK("forced pair", 4'hF, rx_char_clock_pair_oe_o)
  endtask : t_bypass
  task automatic t_frame;
    logic [9:0] raws [4] = '{10'h0FA, 10'h305, 10'h0F9, 10'h155};
    logic [3:0] exp [2] = '{4'h7, 4'h3};
    reframe_allow_i = 1'b1;
    for (int m = 0; m < 2; m++) begin
      cfg(HI, MI, m ? HI : MI, MI);
      `CHECK("frame en", 1'b1, frame_enable_o)
      for (int i = 0; i < 4; i++) begin
        send(0, raws[i], 8'h00, 3'h0);
        `CHECK("hit", exp[m][i], hit)
      end
    end
    reframe_allow_i = 1'b0;
    tick(10);
    send(0, 10'h0FA, 8'h00, 3'h0);
    `CHECK("hit off", 1'b0, hit)
  endtask : t_frame
  task automatic t_train;
    for (int r = 0; r < 2; r++) begin
      training_clock_rate_select_i = r[0];
      rx_clock_rate_select_i = r[0];
      cfg(HI, LO, HI, MI);
      `CHECK("trg drive", rxo_pkg::TRG_CLK_CH, rx_char_clock_pair_oe_o)
      for (int k = 0; k < 6; k++) begin
        @(local_training_clock_i) tick();
        `CHECK("trg a", local_training_clock_i, rx_char_clock_pair_true_o[0])
        `CHECK("trg c", ~local_training_clock_i, rx_char_clock_pair_comp_o[2])
      end
      send(2, 10'h155, r ? 8'h96 : 8'h5A, 3'h1);
      tick(300);
      `CHECK("trg byte", r ? 8'h96 : 8'h5A, rx_byte_out_o[2])
    end
  endtask : t_train
  task automatic report_and_stop;
    $display("mismatches %0d comparisons %0d", n_fail, n_compared);
    if (n_fail == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  initial begin
    #40000;
    n_fail++;
    report_and_stop();
  end
  initial begin
    #1 resetn_i = 1'b0;
    repeat (8) @(posedge clock_i);
    #1 resetn_i = 1'b1;
    tick(5);
    t_decode();
    t_parity();
    t_half();
    t_bypass();
    t_frame();
    t_train();
    report_and_stop();
  end
endmodule : test_rx_output_clocking_parity_framing
